/* File: design/cdcr_pkg.sv */
// constants and types shared by the card and device control register bank
package cdcr_pkg;

    // register offsets in each socket function's configuration space
    localparam logic [7:0] CARD_CTRL_OFFSET   = 8'h91;
    localparam logic [7:0] DEVICE_CTRL_OFFSET = 8'h92;

    // values after reset
    localparam logic [7:0] CARD_CTRL_RESET    = 8'h00;
    localparam logic [7:0] DEVICE_CTRL_RESET  = 8'h66;

    // card control field positions
    localparam int CC_RING_EN_BIT   = 7;
    localparam int CC_VIDEO_EN_BIT  = 6;
    localparam int CC_SPARE_BIT     = 5;
    localparam int CC_AUDIO_RTE_BIT = 2;
    localparam int CC_SPK_EN_BIT    = 1;
    localparam int CC_IRQ_FLAG_BIT  = 0;

    // device control field positions
    localparam int DC_PWR_LOCK_BIT  = 7;
    localparam int DC_LV_CAP_BIT    = 6;
    localparam int DC_DIAG_BIT      = 5;
    localparam int DC_RSVD_BIT      = 4;
    localparam int DC_TEST_BIT      = 3;
    localparam int DC_IRQ_MODE_HI   = 2;
    localparam int DC_IRQ_MODE_LO   = 1;
    localparam int DC_NAND_BIT      = 0;

    // writable masks: reserved bits never store a value
    localparam logic [7:0] CARD_CTRL_WMASK    = 8'he7;
    localparam logic [7:0] DEVICE_CTRL_WMASK  = 8'hef;

    // number of pins taken through the pin input synchroniser
    localparam int SYNC_PINS = 6;

    // interrupt signalling modes
    typedef enum logic [1:0] {
        IRQ_PARALLEL_ONLY = 2'h0,
        IRQ_MODE_RSVD     = 2'h1,
        IRQ_SERIAL_INTAB  = 2'h2,
        IRQ_SERIAL_ALL    = 2'h3
    } cdcr_irq_mode_type;

endpackage : cdcr_pkg

/* File: design/cdcr_sock_if.sv */
// link between the register front end and one socket's card control register
`timescale 1ns/1ps
interface cdcr_sock_if;
    logic       wr_en;      // write to card control via this socket's function
    logic [7:0] wdata;
    logic       irq_evt;    // one-cycle pulse: functional interrupt seen
    logic [7:0] rdata;      // stored socket bits, shared bits absent
    logic       video_en;
    logic       audio_rte;
    logic       spk_en;
    logic       irq_flag;

    modport ctl  (output wr_en, output wdata, output irq_evt,
                  input rdata, input video_en, input audio_rte, input spk_en, input irq_flag);
    modport sock (input wr_en, input wdata, input irq_evt,
                  output rdata, output video_en, output audio_rte, output spk_en, output irq_flag);
endinterface : cdcr_sock_if

/* File: design/cdcr_socket_reg.sv */
// per-socket card control register bits
`timescale 1ns/1ps
module cdcr_socket_reg (
    // clock and reset
    input  wire logic   CLOCK,
    input  wire logic   RSTN,
    // register link
    cdcr_sock_if.sock   bus
);

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic       flag_next;

    // flag: set wins over a write-one clear, writing zero keeps it
    assign flag_next = bus.irq_evt
                     | (ctrl_reg[cdcr_pkg::CC_IRQ_FLAG_BIT]
                        & ~(bus.wr_en & bus.wdata[cdcr_pkg::CC_IRQ_FLAG_BIT]));

    // plain read/write bits take the write, reserved and shared bits stay zero here
    always_comb begin
        ctrl_next = ctrl_reg;
        if (bus.wr_en) begin
            ctrl_next = bus.wdata & cdcr_pkg::CARD_CTRL_WMASK;
        end
        ctrl_next[cdcr_pkg::CC_RING_EN_BIT]  = 1'b0;
        ctrl_next[cdcr_pkg::CC_IRQ_FLAG_BIT] = flag_next;
    end

    // stored bits
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ctrl_reg <= cdcr_pkg::CARD_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // field outputs
    assign bus.rdata     = ctrl_reg;
    assign bus.video_en  = ctrl_reg[cdcr_pkg::CC_VIDEO_EN_BIT];
    assign bus.audio_rte = ctrl_reg[cdcr_pkg::CC_AUDIO_RTE_BIT];
    assign bus.spk_en    = ctrl_reg[cdcr_pkg::CC_SPK_EN_BIT];
    assign bus.irq_flag  = ctrl_reg[cdcr_pkg::CC_IRQ_FLAG_BIT];

endmodule : cdcr_socket_reg

/* File: design/cdcr_top.sv */
// card control and device control registers of a dual-socket card controller
//
// Function
// - Video enable bit 6 maps to socket A via function 0, socket B via 1.
// - Video enable set tri-states that socket's video pins; never starts driving them.
// - Bit 7 ring-indicate output enable is one shared bit, written through function 0, read through both.
// - Bit 2 at 0 routes card audio to the multipurpose pin; socket A wins.
// - Bit 1 forwards card speaker to host speaker; both sockets combined by XOR.
// - Host speaker output drives only while either function's speaker enable is set.
// - Bit 0 per-socket flag set by card functional interrupt, cleared by writing 1.
// - Card control at 91h resets to 00h; bits 4 to 3 read zero.
// - Device control bit 7 blocks socket power-down while in the D3 state.
// - Device control bit 6 forces reported low-voltage capability; resets to 1, shared.
// - Bits 2 to 1 choose interrupt signalling mode; reset value is 11.
// - Device control bit 4 reads zero; writes to it are ignored.
// - Software writes only 0 to bit 3; set, it shortens the interrogation counter.
// - Device control bit 0 enables the input and bidirectional pin diagnostic chain.
// - Device control at 92h in both functions, resets to 66h, shared.
// - Device control bit 5 is a read/write diagnostic bit resetting to 1.
`timescale 1ns/1ps
module cdcr_top (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // configuration access from the host
    input  wire logic        CFG_FUNC,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [7:0]  CFG_WDATA,
    output logic      [7:0]  CFG_RDATA,
    // socket pins, asynchronous
    input  wire logic        CARD_IRQ_A,
    input  wire logic        CARD_IRQ_B,
    input  wire logic        CARD_SPEAKER_IN_A,
    input  wire logic        CARD_SPEAKER_IN_B,
    input  wire logic        CARD_AUDIO_IN_A,
    input  wire logic        CARD_AUDIO_IN_B,
    // socket status outputs
    output logic             CARD_FUNC_IRQ_FLAG_A,
    output logic             CARD_FUNC_IRQ_FLAG_B,
    output logic             ZOOMED_VIDEO_HIZ_A,
    output logic             ZOOMED_VIDEO_HIZ_B,
    // audio and speaker outputs
    output logic             HOST_SPEAKER_OUT,
    output logic             HOST_SPEAKER_OE,
    output logic             CARD_AUDIO_PWM_OUT,
    output logic             CARD_AUDIO_PWM_OE,
    output logic             RING_OUT_ENABLE,
    // power management
    input  wire logic        D3_STATE,
    input  wire logic        SOCKET_PWRDOWN_REQ,
    output logic             SOCKET_PWRDOWN_GRANT,
    // shared device settings
    output logic             LOW_VOLT_CAPABLE_FORCE,
    output logic             DIAG_CTRL_BIT,
    output logic             TEST_SHORT_COUNT,
    output logic [1:0]       IRQ_SIGNAL_SELECT,
    output logic             NAND_TREE_EN
);

    // socket register links
    cdcr_sock_if sock_a ();
    cdcr_sock_if sock_b ();

    // pin synchroniser, three stages; a level counts once stages two and three agree
    logic [cdcr_pkg::SYNC_PINS-1:0] pin_raw;
    logic [cdcr_pkg::SYNC_PINS-1:0] sync1_reg;
    logic [cdcr_pkg::SYNC_PINS-1:0] sync2_reg;
    logic [cdcr_pkg::SYNC_PINS-1:0] sync3_reg;
    logic [cdcr_pkg::SYNC_PINS-1:0] pin_reg;
    logic [cdcr_pkg::SYNC_PINS-1:0] pin_next;
    logic [cdcr_pkg::SYNC_PINS-1:0] pin_agree;

    // shared register state
    logic       ring_en_reg;
    logic       ring_en_next;
    logic [7:0] dev_reg;
    logic [7:0] dev_next;

    // decoded access strobes
    wire        hit_card   = (CFG_ADDR == cdcr_pkg::CARD_CTRL_OFFSET);
    wire        hit_dev    = (CFG_ADDR == cdcr_pkg::DEVICE_CTRL_OFFSET);
    wire        wr_card_a  = CFG_WR & hit_card & ~CFG_FUNC;
    wire        wr_card_b  = CFG_WR & hit_card & CFG_FUNC;
    wire        wr_dev     = CFG_WR & hit_dev;

    // filtered pin levels and derived events
    wire        irq_lvl_a  = pin_reg[0];
    wire        irq_lvl_b  = pin_reg[1];
    wire        spk_a      = pin_reg[2];
    wire        spk_b      = pin_reg[3];
    wire        aud_a      = pin_reg[4];
    wire        aud_b      = pin_reg[5];
    wire        irq_rise_a = pin_next[0] & ~pin_reg[0];
    wire        irq_rise_b = pin_next[1] & ~pin_reg[1];

    // read data select
    logic [7:0] card_view;
    logic [7:0] rdata_next;
    logic       spk_next;
    logic       spk_oe_next;
    logic       aud_next;
    logic       aud_oe_next;
    logic       grant_next;

    assign pin_raw   = {CARD_AUDIO_IN_B, CARD_AUDIO_IN_A, CARD_SPEAKER_IN_B,
                        CARD_SPEAKER_IN_A, CARD_IRQ_B, CARD_IRQ_A};
    assign pin_agree = ~(sync2_reg ^ sync3_reg);
    // only bits whose last two stages agree move the filtered level
    assign pin_next  = (pin_agree & sync3_reg) | (~pin_agree & pin_reg);

    // synchroniser chain; first stage feeds only the second
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_reg   <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg   <= pin_next;
        end
    end

    // socket register links: function 0 reaches socket A, function 1 socket B
    assign sock_a.wr_en   = wr_card_a;
    assign sock_a.wdata   = CFG_WDATA;
    assign sock_a.irq_evt = irq_rise_a;
    assign sock_b.wr_en   = wr_card_b;
    assign sock_b.wdata   = CFG_WDATA;
    assign sock_b.irq_evt = irq_rise_b;

    cdcr_socket_reg u_sock_a (
        .CLOCK (CLOCK),
        .RSTN  (RSTN),
        .bus   (sock_a.sock)
    );

    cdcr_socket_reg u_sock_b (
        .CLOCK (CLOCK),
        .RSTN  (RSTN),
        .bus   (sock_b.sock)
    );

    // shared ring enable: a function 1 write leaves it alone so the two views cannot fight
    assign ring_en_next = wr_card_a ? CFG_WDATA[cdcr_pkg::CC_RING_EN_BIT] : ring_en_reg;

    // device control: one copy for both functions, bit 4 never stored
    assign dev_next = wr_dev ? (CFG_WDATA & cdcr_pkg::DEVICE_CTRL_WMASK) : dev_reg;

    // shared registers
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ring_en_reg <= 1'b0;
            dev_reg     <= cdcr_pkg::DEVICE_CTRL_RESET;
        end else begin
            ring_en_reg <= ring_en_next;
            dev_reg     <= dev_next;
        end
    end

    // card control view of the addressed function; bits 4 to 3 come back zero
    always_comb begin
        card_view = CFG_FUNC ? sock_b.rdata : sock_a.rdata;
        card_view[cdcr_pkg::CC_RING_EN_BIT] = ring_en_reg;
        card_view = card_view & cdcr_pkg::CARD_CTRL_WMASK;
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        if (hit_card) begin
            rdata_next = card_view;
        end else if (hit_dev) begin
            rdata_next = dev_reg & cdcr_pkg::DEVICE_CTRL_WMASK;
        end else begin
            rdata_next = 8'h00;
        end
    end

    // speaker: exclusive-or of enabled sockets, driven while either enable is set
    assign spk_next    = (spk_a & sock_a.spk_en) ^ (spk_b & sock_b.spk_en);
    assign spk_oe_next = sock_a.spk_en | sock_b.spk_en;

    // audio route: a zero selects routing, socket A takes the pin when both ask
    always_comb begin
        aud_next    = 1'b0;
        aud_oe_next = 1'b1;
        if (!sock_a.audio_rte) begin
            aud_next = aud_a;
        end else if (!sock_b.audio_rte) begin
            aud_next = aud_b;
        end else begin
            aud_oe_next = 1'b0;
        end
    end

    // power-down allowed unless locked while in D3
    assign grant_next = SOCKET_PWRDOWN_REQ
                      & ~(dev_reg[cdcr_pkg::DC_PWR_LOCK_BIT] & D3_STATE);

    // registered outputs
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            CFG_RDATA            <= 8'h00;
            HOST_SPEAKER_OUT     <= 1'b0;
            HOST_SPEAKER_OE      <= 1'b0;
            CARD_AUDIO_PWM_OUT   <= 1'b0;
            CARD_AUDIO_PWM_OE    <= 1'b0;
            SOCKET_PWRDOWN_GRANT <= 1'b0;
        end else begin
            if (CFG_RD) begin
                CFG_RDATA <= rdata_next;
            end
            HOST_SPEAKER_OUT     <= spk_next & spk_oe_next;
            HOST_SPEAKER_OE      <= spk_oe_next;
            CARD_AUDIO_PWM_OUT   <= aud_next;
            CARD_AUDIO_PWM_OE    <= aud_oe_next;
            SOCKET_PWRDOWN_GRANT <= grant_next;
        end
    end

    // straight register fields; video enable only ever removes drive, never adds it
    assign CARD_FUNC_IRQ_FLAG_A   = sock_a.irq_flag;
    assign CARD_FUNC_IRQ_FLAG_B   = sock_b.irq_flag;
    assign ZOOMED_VIDEO_HIZ_A     = sock_a.video_en;
    assign ZOOMED_VIDEO_HIZ_B     = sock_b.video_en;
    assign RING_OUT_ENABLE        = ring_en_reg;
    assign LOW_VOLT_CAPABLE_FORCE = dev_reg[cdcr_pkg::DC_LV_CAP_BIT];
    assign DIAG_CTRL_BIT          = dev_reg[cdcr_pkg::DC_DIAG_BIT];
    assign TEST_SHORT_COUNT       = dev_reg[cdcr_pkg::DC_TEST_BIT];
    assign IRQ_SIGNAL_SELECT      = dev_reg[cdcr_pkg::DC_IRQ_MODE_HI:cdcr_pkg::DC_IRQ_MODE_LO];
    assign NAND_TREE_EN           = dev_reg[cdcr_pkg::DC_NAND_BIT];

    // unused filtered levels of the interrupt pins are consumed by an exclusive-or here
    logic unused_lvl;
    assign unused_lvl = irq_lvl_a ^ irq_lvl_b;

endmodule : cdcr_top

/* File: verif/cdcr_card_model.sv */
// card side of both sockets: interrupt, speaker and audio levels
`timescale 1ns/1ps
module cdcr_card_model (
    // clock
    input  wire logic       clk,
    // levels wanted, {aud_b, aud_a, spk_b, spk_a, irq_b, irq_a}
    input  wire logic [5:0] want,
    // socket pins
    output logic      [5:0] pins
);
    // pins move 3 ns after the edge, as an unsynchronised card would
    initial pins = 6'h00;
    always @(posedge clk) begin
        pins <= #3 want;
    end
endmodule : cdcr_card_model

/* File: verif/cdcr_checker.sv */
// port assertions for the card and device control register bank
`timescale 1ns/1ps
module cdcr_checker (
    // clock, reset and register port
    input wire logic       CLOCK,
    input wire logic       RSTN,
    input wire logic       CFG_FUNC,
    input wire logic [7:0] CFG_ADDR,
    input wire logic       CFG_WR,
    input wire logic       CFG_RD,
    input wire logic [7:0] CFG_WDATA,
    input wire logic [7:0] CFG_RDATA,
    // pins and settings
    input wire logic       CARD_IRQ_A,
    input wire logic       CARD_FUNC_IRQ_FLAG_A,
    input wire logic       ZOOMED_VIDEO_HIZ_A,
    input wire logic       RING_OUT_ENABLE,
    input wire logic       LOW_VOLT_CAPABLE_FORCE,
    input wire logic       DIAG_CTRL_BIT,
    input wire logic       TEST_SHORT_COUNT,
    input wire logic [1:0] IRQ_SIGNAL_SELECT,
    input wire logic       NAND_TREE_EN
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // write decodes; function 1 must never reach the shared ring bit
    wire logic cc_wr_f0 = CFG_WR && CFG_ADDR == 8'h91 && !CFG_FUNC;
    wire logic dc_wr    = CFG_WR && CFG_ADDR == 8'h92;
    property p_video_a;
        cc_wr_f0 |=> ZOOMED_VIDEO_HIZ_A == $past(CFG_WDATA[6]);
    endproperty
    a_video_a: assert property (p_video_a) else $error("video a mismatch");
    property p_ring;
        $changed(RING_OUT_ENABLE) |-> $past(cc_wr_f0);
    endproperty
    a_ring: assert property (p_ring) else $error("ring changed without write");
    property p_irq_set;
        $rose(CARD_FUNC_IRQ_FLAG_A) |-> $past(CARD_IRQ_A, 3);
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("flag rose without pin");
    property p_irq_clr;
        $fell(CARD_FUNC_IRQ_FLAG_A) |-> $past(cc_wr_f0 && CFG_WDATA[0]);
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("flag fell without clear");
    property p_devctl;
        dc_wr |=> {LOW_VOLT_CAPABLE_FORCE, DIAG_CTRL_BIT, TEST_SHORT_COUNT, IRQ_SIGNAL_SELECT, NAND_TREE_EN}
            == {$past(CFG_WDATA[6:5]), $past(CFG_WDATA[3:0])};
    endproperty
    a_devctl: assert property (p_devctl) else $error("device settings mismatch");
    property p_rd_cc;
        CFG_RD && CFG_ADDR == 8'h91 |=> CFG_RDATA[4:3] == 2'h0;
    endproperty
    a_rd_cc: assert property (p_rd_cc) else $error("card control reserved bits");
    property p_rd_dc;
        CFG_RD && CFG_ADDR == 8'h92 |=> !CFG_RDATA[4];
    endproperty
    a_rd_dc: assert property (p_rd_dc) else $error("device control bit 4 set");
    property p_rd_hold;
        !CFG_RD |=> $stable(CFG_RDATA);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : cdcr_checker

bind cdcr_top cdcr_checker u_chk (.CLOCK, .RSTN, .CFG_FUNC, .CFG_ADDR, .CFG_WR, .CFG_RD, .CFG_WDATA,
    .CFG_RDATA, .CARD_IRQ_A, .CARD_FUNC_IRQ_FLAG_A, .ZOOMED_VIDEO_HIZ_A, .RING_OUT_ENABLE,
    .LOW_VOLT_CAPABLE_FORCE, .DIAG_CTRL_BIT, .TEST_SHORT_COUNT, .IRQ_SIGNAL_SELECT, .NAND_TREE_EN);

/* File: verif/tb.sv */
// self-checking bench for the card and device control register bank
`timescale 1ns/1ps
module tb;
    logic       clk, rstn, func, wr, rd, d3, req;
    logic [7:0] addr, wdata, rdata, a, b, d;
    logic [5:0] want, pins;
    logic       fl_a, fl_b, hz_a, hz_b, spk, spk_oe, aud, aud_oe, ring, grant, lv, dg, tst, nand_en;
    logic [1:0] sel;
    int         failures, cmp_count;

    cdcr_top DUT (.CLOCK(clk), .RSTN(rstn), .CFG_FUNC(func), .CFG_ADDR(addr), .CFG_WR(wr), .CFG_RD(rd),
        .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CARD_IRQ_A(pins[0]), .CARD_IRQ_B(pins[1]),
        .CARD_SPEAKER_IN_A(pins[2]), .CARD_SPEAKER_IN_B(pins[3]), .CARD_AUDIO_IN_A(pins[4]),
        .CARD_AUDIO_IN_B(pins[5]), .CARD_FUNC_IRQ_FLAG_A(fl_a), .CARD_FUNC_IRQ_FLAG_B(fl_b),
        .ZOOMED_VIDEO_HIZ_A(hz_a), .ZOOMED_VIDEO_HIZ_B(hz_b), .HOST_SPEAKER_OUT(spk), .HOST_SPEAKER_OE(spk_oe),
        .CARD_AUDIO_PWM_OUT(aud), .CARD_AUDIO_PWM_OE(aud_oe), .RING_OUT_ENABLE(ring), .D3_STATE(d3),
        .SOCKET_PWRDOWN_REQ(req), .SOCKET_PWRDOWN_GRANT(grant), .LOW_VOLT_CAPABLE_FORCE(lv),
        .DIAG_CTRL_BIT(dg), .TEST_SHORT_COUNT(tst), .IRQ_SIGNAL_SELECT(sel), .NAND_TREE_EN(nand_en));
    cdcr_card_model u_card (.clk(clk), .want(want), .pins(pins));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // compare and count
    task check(input string nm, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_n
    // one-cycle strobes, held until the taking edge
    task wr_reg(input logic f, input logic [7:0] ad, dt);
        @(posedge clk);
        func <= f;
        addr <= ad;
        wdata <= dt;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task rd_chk(input logic f, input logic [7:0] ad, exp);
        @(posedge clk);
        func <= f;
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check("rdata", rdata, exp);
    endtask : rd_chk
    // card control as read through one function: ring is shared, rest per socket
    function automatic logic [7:0] cc_exp(input logic [7:0] own, rg, input logic fl);
        return {rg[7], own[6:5], 2'h0, own[2:1], fl};
    endfunction : cc_exp
    task end_of_test();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // roughly 270 cycles of traffic; a hang is cut well beyond that
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_of_test();
    end

    initial begin
        {rstn, func, wr, rd, d3, req} = 6'h00;
        {addr, wdata, want} = 22'h0;
        failures = 0;
        cmp_count = 0;
        void'($urandom(32'h6fb5));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        wait_n(1);
        rd_chk(0, 8'h91, 8'h00);
        rd_chk(1, 8'h92, 8'h66);
        check("devout", {lv, dg, tst, sel, nand_en}, 8'h36);
        // every interrupt mode, bit 4 set in the last write, both functions
        for (int i = 0; i < 8; i++) begin
            d = i == 7 ? 8'hf7 : 8'($urandom());
            d[2:1] = i[1:0];
            d[3] = 1'b0;
            wr_reg(i[0], 8'h92, d);
            rd_chk(!i[0], 8'h92, d & 8'hef);
            check("devout", {lv, dg, tst, sel, nand_en}, {d[6:5], d[3:0]});
        end
        // power lock is set by the last write
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            d3 <= i[0];
            req <= i[1];
            wait_n(2);
            check("grant", grant, i[1] & !i[0]);
        end
        wr_reg(0, 8'h92, 8'h66);
        wait_n(1);
        check("grant", grant, 8'h01);
        // enable combinations walk through all of bits 2:1 of socket A and values 00 to 10 of socket B
        for (int i = 0; i < 12; i++) begin
            a = 8'($urandom());
            b = 8'($urandom());
            a[2:0] = {i[1:0], 1'b0};
            b[2:0] = {i[3:2], 1'b0};
            want <= 6'($urandom()) & 6'h3c;
            wr_reg(0, 8'h91, a);
            wr_reg(1, 8'h91, b);
            wait_n(6);
            rd_chk(0, 8'h91, cc_exp(a, a, 1'b0));
            rd_chk(1, 8'h91, cc_exp(b, a, 1'b0));
            check("hiz", {hz_b, hz_a, ring}, {b[6], a[6], a[7]});
            check("spk", {spk_oe, spk}, {a[1] | b[1], (a[1] & want[2]) ^ (b[1] & want[3])});
            check("aud_oe", aud_oe, !(a[2] & b[2]));
            if (!(a[2] & b[2])) check("aud", aud, a[2] ? want[5] : want[4]);
        end
        // pin held high through the clear must not set the flag again
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            want <= 6'h01 << s;
            wait_n(8);
            check("flags", {fl_b, fl_a}, 2'h1 << s);
            wr_reg(s[0], 8'h91, 8'h00);
            wr_reg(!s[0], 8'h91, 8'h01);
            check("flags", {fl_b, fl_a}, 2'h1 << s);
            wr_reg(s[0], 8'h91, 8'h01);
            wait_n(4);
            check("flags", {fl_b, fl_a}, 8'h00);
            want <= 6'h00;
            wait_n(6);
        end
        end_of_test();
    end
endmodule : tb
